// ==== inc/hires_period_enable_regs.vh ====
// Constants for the high-resolution PWM edge scaling block
`ifndef HIRES_PERIOD_ENABLE_REGS_VH
`define HIRES_PERIOD_ENABLE_REGS_VH
// ****************************************************************
// Configuration field positions
// ****************************************************************
`define HIRES_PERIOD_ENABLE_CFG_AUTO_BIT 6
`define HIRES_PERIOD_ENABLE_FINE_MSB 15
`define HIRES_PERIOD_ENABLE_FINE_LSB 8
// ****************************************************************
// Count modes
// ****************************************************************
`define HIRES_PERIOD_ENABLE_MODE_UP 2'h0
`define HIRES_PERIOD_ENABLE_MODE_DOWN 2'h1
`define HIRES_PERIOD_ENABLE_MODE_UPDOWN 2'h2
// ****************************************************************
// Reset values
// ****************************************************************
`define HIRES_PERIOD_ENABLE_RST_WORD 32'h0000_0000
`define HIRES_PERIOD_ENABLE_RST_STEPS 8'h00
// ****************************************************************
// Arithmetic and timing
// ****************************************************************
`define HIRES_PERIOD_ENABLE_ROUND_HALF 16'h0080
`define HIRES_PERIOD_ENABLE_GUARD_CYC 16'h0003
`define HIRES_PERIOD_ENABLE_ELAPSED_MAX 2'h3
`endif

// ==== logic/hires_period_enable_top.v ====
// High-resolution PWM channel with fine duty and fine period edge scaling
`timescale 1ns/1ns
`include "hires_period_enable_regs.vh"

module hires_period_enable_top
#(
    parameter CW = 16
)
(
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Duty word {coarse, fine} and its write strobe
    input wire [31:0] duty_word,
    input wire duty_word_wr,
    // Period mirror word {coarse, fine} and its write strobe
    input wire [31:0] period_mirror_word,
    input wire period_mirror_wr,
    // Configuration
    input wire [7:0] hires_config,
    input wire hires_period_enable,
    input wire [7:0] steps_per_coarse_factor,
    input wire [1:0] count_mode,
    input wire sync_pulse,
    // PWM outputs
    output reg pwm_out_a,
    output reg pwm_out_b,
    // Micro edge positioner commands
    output reg duty_edge_strobe,
    output reg [7:0] duty_fine_steps,
    output reg period_edge_strobe,
    output reg [7:0] period_fine_steps,
    output reg fine_window_open,
    // Time-base state
    output reg [CW-1:0] time_base_counter
);

    // ****************************************************************
    // Fine delay conversion
    // ****************************************************************
    // Turns a 16-bit fine register into micro steps
    function [7:0] fine_steps;
        input [15:0] fine;
        input [7:0] factor;
        input auto;
        reg [15:0] prod;
        begin
            prod = {8'h00, fine[`HIRES_PERIOD_ENABLE_FINE_MSB:`HIRES_PERIOD_ENABLE_FINE_LSB]} * {8'h00, factor};
            if (auto)
            begin
                // Product plus half, then drop the fraction byte
                fine_steps = prod_round(prod);
            end
            else
            begin
                // Software already scaled; low byte ignored
                fine_steps = fine[`HIRES_PERIOD_ENABLE_FINE_MSB:`HIRES_PERIOD_ENABLE_FINE_LSB];
            end
        end
    endfunction

    // Rounds a Q8 product to whole steps, 255*255 fits in 8 bits after shift
    function [7:0] prod_round;
        input [15:0] p;
        reg [16:0] s;
        begin
            s = {1'b0, p} + {1'b0, `HIRES_PERIOD_ENABLE_ROUND_HALF};
            prod_round = s[15:8];
        end
    endfunction

    // ****************************************************************
    // Shadow and active registers
    // ****************************************************************
    reg [CW-1:0] duty_coarse_compare_r;
    reg [15:0] duty_fine_compare_r;
    reg [CW-1:0] period_coarse_mirror_r;
    reg [15:0] period_fine_mirror_r;
    reg [CW-1:0] cmp_act_r;
    reg [15:0] cfine_act_r;
    reg [CW-1:0] period_act_r;
    reg [15:0] pfine_act_r;
    // Time-base state
    reg [CW-1:0] cnt_r;
    reg [CW-1:0] cnt_nxt;
    reg dir_up_r;
    reg dir_up_nxt;
    reg [1:0] elapsed_r;
    reg start_nxt;
    reg end_now;
    // Window and edge terms
    reg window;
    wire a_nxt;
    wire auto_conv;
    wire [CW-1:0] to_end;
    wire hires_period_enable_on;

    assign auto_conv = hires_config[`HIRES_PERIOD_ENABLE_CFG_AUTO_BIT];
    assign to_end = period_act_r - cnt_r;
    // Hires period is not used with count-down mode
    assign hires_period_enable_on = hires_period_enable && (count_mode != `HIRES_PERIOD_ENABLE_MODE_DOWN);

    // Shadow loads; one word updates coarse and fine together
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            duty_coarse_compare_r <= {CW{1'b0}};
            duty_fine_compare_r <= 16'h0000;
            period_coarse_mirror_r <= {CW{1'b0}};
            period_fine_mirror_r <= 16'h0000;
        end
        else
        begin
            if (duty_word_wr)
            begin
                duty_coarse_compare_r <= duty_word[31:16];
                duty_fine_compare_r <= duty_word[15:0];
            end
            if (period_mirror_wr)
            begin
                period_coarse_mirror_r <= period_mirror_word[31:16];
                period_fine_mirror_r <= period_mirror_word[15:0];
            end
        end
    end

    // ****************************************************************
    // Time-base counter
    // ****************************************************************
    // Next count, direction and period boundary
    always @*
    begin
        cnt_nxt = cnt_r;
        dir_up_nxt = dir_up_r;
        start_nxt = 1'b0;
        end_now = 1'b0;
        case (count_mode)
            `HIRES_PERIOD_ENABLE_MODE_DOWN:
            begin
                // Period value down to 0: period+1 cycles
                if (cnt_r == {CW{1'b0}})
                begin
                    cnt_nxt = period_act_r;
                    start_nxt = 1'b1;
                    end_now = 1'b1;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
                dir_up_nxt = 1'b0;
            end
            `HIRES_PERIOD_ENABLE_MODE_UPDOWN:
            begin
                // 0 up to period value, back down to 1: twice the period value
                if (period_act_r == {CW{1'b0}})
                begin
                    cnt_nxt = {CW{1'b0}};
                    dir_up_nxt = 1'b1;
                    start_nxt = 1'b1;
                end
                else if (dir_up_r)
                begin
                    if (cnt_r >= period_act_r)
                    begin
                        cnt_nxt = period_act_r - 1'b1;
                        dir_up_nxt = 1'b0;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
                else if (cnt_r <= {{(CW-1){1'b0}}, 1'b1})
                begin
                    cnt_nxt = {CW{1'b0}};
                    dir_up_nxt = 1'b1;
                    start_nxt = 1'b1;
                    end_now = 1'b1;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default:
            begin
                // 0 up to period value: period+1 cycles
                if (cnt_r >= period_act_r)
                begin
                    cnt_nxt = {CW{1'b0}};
                    start_nxt = 1'b1;
                    end_now = 1'b1;
                end
                else
                begin
                    cnt_nxt = cnt_r + 1'b1;
                end
                dir_up_nxt = 1'b1;
            end
        endcase
        // Sync restarts the time base; output B stays the inverse of A across it
        if (sync_pulse)
        begin
            cnt_nxt = {CW{1'b0}};
            dir_up_nxt = 1'b1;
            start_nxt = 1'b1;
        end
    end

    // Counter, direction, elapsed cycles and shadow-to-active transfer
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cnt_r <= {CW{1'b0}};
            dir_up_r <= 1'b1;
            elapsed_r <= 2'h0;
            cmp_act_r <= {CW{1'b0}};
            cfine_act_r <= 16'h0000;
            period_act_r <= {CW{1'b0}};
            pfine_act_r <= 16'h0000;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            dir_up_r <= dir_up_nxt;
            if (start_nxt)
            begin
                elapsed_r <= 2'h0;
                cmp_act_r <= duty_coarse_compare_r;
                cfine_act_r <= duty_fine_compare_r;
                period_act_r <= period_coarse_mirror_r;
                pfine_act_r <= period_fine_mirror_r;
            end
            else if (elapsed_r != `HIRES_PERIOD_ENABLE_ELAPSED_MAX)
            begin
                elapsed_r <= elapsed_r + 2'h1;
            end
        end
    end

    // ****************************************************************
    // Fine placement window
    // ****************************************************************
    // Window in which the micro edge positioner may act
    always @*
    begin
        if (hires_period_enable_on)
        begin
            // Both modes: 3 past zero/match and 3 before match/zero
            window = (cnt_r >= `HIRES_PERIOD_ENABLE_GUARD_CYC) && (to_end >= `HIRES_PERIOD_ENABLE_GUARD_CYC);
        end
        else
        begin
            // Only the start of the period is guarded
            window = (elapsed_r == `HIRES_PERIOD_ENABLE_ELAPSED_MAX);
        end
    end

    // Coarse output level: high while count below compare, zero duty never high
    assign a_nxt = (cnt_r < cmp_act_r);

    // ****************************************************************
    // Output registers
    // ****************************************************************
    // PWM pins, edge strobes and fine step commands
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pwm_out_a <= 1'b0;
            pwm_out_b <= 1'b1;
            duty_edge_strobe <= 1'b0;
            duty_fine_steps <= `HIRES_PERIOD_ENABLE_RST_STEPS;
            period_edge_strobe <= 1'b0;
            period_fine_steps <= `HIRES_PERIOD_ENABLE_RST_STEPS;
            fine_window_open <= 1'b0;
            time_base_counter <= {CW{1'b0}};
        end
        else
        begin
            pwm_out_a <= a_nxt;
            // B is the inverse of A in every mode, also across a sync
            pwm_out_b <= ~a_nxt;
            fine_window_open <= window;
            time_base_counter <= cnt_r;
            duty_edge_strobe <= (a_nxt != pwm_out_a);
            if ((a_nxt != pwm_out_a) && window)
            begin
                duty_fine_steps <= fine_steps(cfine_act_r, steps_per_coarse_factor,
                                              auto_conv);
            end
            else
            begin
                duty_fine_steps <= `HIRES_PERIOD_ENABLE_RST_STEPS;
            end
            period_edge_strobe <= end_now;
            if (end_now && hires_period_enable_on)
            begin
                // Period extension always uses the hardware scaling
                period_fine_steps <= fine_steps(pfine_act_r, steps_per_coarse_factor,
                                                1'b1);
            end
            else
            begin
                period_fine_steps <= `HIRES_PERIOD_ENABLE_RST_STEPS;
            end
        end
    end

endmodule // hires_period_enable_top

// ==== verif/hires_period_enable_monitor.sv ====
// Assertion checker for the high-resolution PWM block
`timescale 1ns/1ns
`include "hires_period_enable_regs.vh"
module hires_period_enable_monitor
#(
    parameter CW = 16
)
(
    // Clock, reset and configuration
    input wire sys_clk,
    input wire rst_n,
    input wire [7:0] hires_config,
    input wire hires_period_enable,
    input wire [7:0] steps_per_coarse_factor,
    input wire [1:0] count_mode,
    // Outputs
    input wire pwm_out_a,
    input wire pwm_out_b,
    input wire duty_edge_strobe,
    input wire [7:0] duty_fine_steps,
    input wire period_edge_strobe,
    input wire [7:0] period_fine_steps,
    input wire fine_window_open,
    input wire [CW-1:0] time_base_counter
);
// ****
// Edge and window checks
// ****
default clocking dc @(posedge sys_clk);
endclocking
default disable iff (!rst_n);
a_b_inverse: assert property (pwm_out_b == !pwm_out_a)
    else $error("b not inverse of a");
a_strobe_on_edge: assert property (duty_edge_strobe == (pwm_out_a != $past(pwm_out_a)))
    else $error("duty strobe not with edge");
a_steps_idle: assert property (!duty_edge_strobe |-> duty_fine_steps == 8'h00)
    else $error("duty steps without edge");
a_steps_window: assert property (duty_edge_strobe && !fine_window_open |-> duty_fine_steps == 8'h00)
    else $error("fine steps outside window");
a_steps_scaled: assert property ($past(hires_config[`HIRES_PERIOD_ENABLE_CFG_AUTO_BIT])
    && duty_edge_strobe |-> duty_fine_steps <= $past(steps_per_coarse_factor))
    else $error("scaled steps above factor");
a_period_quiet: assert property (!period_edge_strobe || !$past(hires_period_enable)
    |-> period_fine_steps == 8'h00)
    else $error("period steps when not allowed");
a_up_guard: assert property ($past(hires_period_enable) && count_mode == `HIRES_PERIOD_ENABLE_MODE_UP
    && time_base_counter < 3 |-> !fine_window_open)
    else $error("window open near up period start");
a_start_guard: assert property (!hires_period_enable && count_mode == `HIRES_PERIOD_ENABLE_MODE_UP
    && $rose(fine_window_open) |-> time_base_counter == 3)
    else $error("window opened at wrong count");
a_updown_guard: assert property ($past(hires_period_enable)
    && count_mode == `HIRES_PERIOD_ENABLE_MODE_UPDOWN && time_base_counter < 3 |-> !fine_window_open)
    else $error("window open near zero in up-down");
endmodule // hires_period_enable_monitor
bind hires_period_enable_top hires_period_enable_monitor #(.CW(CW)) hires_period_enable_monitor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .hires_config(hires_config), .hires_period_enable(hires_period_enable),
    .steps_per_coarse_factor(steps_per_coarse_factor), .count_mode(count_mode),
    .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b), .duty_edge_strobe(duty_edge_strobe),
    .duty_fine_steps(duty_fine_steps), .period_edge_strobe(period_edge_strobe),
    .period_fine_steps(period_fine_steps), .fine_window_open(fine_window_open),
    .time_base_counter(time_base_counter));

// ==== verif/hires_period_enable_stage.sv ====
// Switching stage model that measures the PWM waveform it receives
`timescale 1ns/1ns
module hires_period_enable_stage
(
    // Drive signals
    input wire sys_clk,
    input wire pwm_out_a,
    // Measured waveform
    output reg [15:0] period_cycles,
    output reg [15:0] on_cycles
);
reg [15:0] cnt_r = 16'h0000;
reg a_r = 1'b0;
// ****
// Period and on-time measurement
// ****
// Count from each rise of a; latch on-time at the fall
always @(posedge sys_clk)
begin
    a_r <= pwm_out_a;
    cnt_r <= cnt_r + 16'h0001;
    if (pwm_out_a && !a_r)
    begin
        period_cycles <= cnt_r;
        cnt_r <= 16'h0001;
    end
    if (!pwm_out_a && a_r)
        on_cycles <= cnt_r;
end
endmodule // hires_period_enable_stage

// ==== verif/hires_period_enable_top_test.sv ====
// Self-checking bench for the high-resolution PWM block
`timescale 1ns/1ns
`include "hires_period_enable_regs.vh"
module hires_period_enable_top_test;
reg sys_clk = 1'b0;
reg rst_n = 1'b0;
reg [31:0] duty_word = 32'h0, period_mirror_word = 32'h0;
reg duty_word_wr = 1'b0, period_mirror_wr = 1'b0, hires_period_enable = 1'b0, sync_pulse = 1'b0;
reg [7:0] hires_config = 8'h00, steps_per_coarse_factor = 8'h00, rk;
reg [1:0] count_mode = 2'h0, watch = 2'h0;
reg [15:0] rf;
wire pwm_out_a, pwm_out_b, duty_edge_strobe, period_edge_strobe, fine_window_open;
wire [7:0] duty_fine_steps, period_fine_steps;
wire [15:0] time_base_counter, period_cycles, on_cycles;
integer num_errors = 0, checked = 0, cycles = 0, seed = 32'h5803, i;
reg [7:0] q[$];
hires_period_enable_top hires_period_enable_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .duty_word(duty_word),
    .duty_word_wr(duty_word_wr), .period_mirror_word(period_mirror_word),
    .period_mirror_wr(period_mirror_wr), .hires_config(hires_config),
    .hires_period_enable(hires_period_enable), .steps_per_coarse_factor(steps_per_coarse_factor),
    .count_mode(count_mode), .sync_pulse(sync_pulse), .pwm_out_a(pwm_out_a),
    .pwm_out_b(pwm_out_b), .duty_edge_strobe(duty_edge_strobe), .duty_fine_steps(duty_fine_steps),
    .period_edge_strobe(period_edge_strobe), .period_fine_steps(period_fine_steps),
    .fine_window_open(fine_window_open), .time_base_counter(time_base_counter));
hires_period_enable_stage hires_period_enable_stage_inst (.sys_clk(sys_clk), .pwm_out_a(pwm_out_a),
    .period_cycles(period_cycles), .on_cycles(on_cycles));
// ****
// Clock, timeout and result watcher
// ****
initial
begin
    forever #5 sys_clk = ~sys_clk;
end
// Cut a hang short
always @(posedge sys_clk)
begin
    cycles = cycles + 1;
    if (cycles == 10000)
    begin
        num_errors = num_errors + 1;
        test_done;
    end
end
// Compare the oldest note with each selected edge result
always @(posedge sys_clk)
begin
    if (watch != 2'h0 && q.size() > 0 && (watch == 2'h3 ? period_edge_strobe
        : duty_edge_strobe && pwm_out_a == watch[1]))
        cmp(watch == 2'h3 ? period_fine_steps : duty_fine_steps, q.pop_front());
end
task cmp(input [15:0] g, input [15:0] e);
begin
    checked = checked + 1;
    if (g !== e)
    begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
end
endtask
// Fine steps from the upper byte, scaled when auto-convert is on
function [7:0] scale(input [15:0] f, input [7:0] k, input au);
    scale = au ? (({9'h0, f[15:8]} * k + 17'h80) >> 8) : f[15:8];
endfunction
// One configuration: reset, write words, restart, watch two edges, measure
task scen(input [1:0] m, input h, input au, input [7:0] k, input [15:0] c, input [15:0] f,
    input [15:0] p, input [15:0] pf, input [1:0] w, input win, input [15:0] per, input [15:0] on);
    reg [7:0] e;
    integer n;
begin
    e = w == 2'h3 ? scale(pf, k, 1'b1) : (win ? scale(f, k, au) : 8'h00);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    count_mode <= m;
    hires_period_enable <= h;
    hires_config <= {1'b0, au, 6'h0};
    steps_per_coarse_factor <= k;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    duty_word <= {c, f};
    period_mirror_word <= {p, pf};
    duty_word_wr <= 1'b1;
    period_mirror_wr <= 1'b1;
    @(posedge sys_clk);
    duty_word_wr <= 1'b0;
    period_mirror_wr <= 1'b0;
    sync_pulse <= 1'b1;
    @(posedge sys_clk);
    sync_pulse <= 1'b0;
    repeat (40) @(posedge sys_clk);
    // Notes only when edges are watched, so an idle scenario leaves the queue empty
    if (w != 2'h0)
    begin
        q.push_back(e);
        q.push_back(e);
    end
    watch <= w;
    for (n = 0; n < 100 && w != 2'h0 && q.size() > 0; n = n + 1)
        @(posedge sys_clk);
    watch <= 2'h0;
    cmp(q.size(), 0);
    q.delete();
    if (per != 16'h0)
    begin
        cmp(period_cycles, per);
        cmp(on_cycles, on);
    end
    else
        for (n = 0; n < 25; n = n + 1)
            @(negedge sys_clk) cmp({15'h0, pwm_out_a}, 16'h0);
end
endtask
// ****
// Main sequence
// ****
initial
begin
    scen(`HIRES_PERIOD_ENABLE_MODE_UP, 0, 0, 93, 5, 16'h25b3, 9, 0, 1, 1, 10, 5);
    scen(`HIRES_PERIOD_ENABLE_MODE_UP, 0, 1, 93, 5, 16'hdbff, 9, 0, 1, 1, 10, 5);
    scen(`HIRES_PERIOD_ENABLE_MODE_UP, 0, 1, 93, 2, 16'hdb00, 9, 0, 1, 0, 10, 2);
    scen(`HIRES_PERIOD_ENABLE_MODE_UP, 1, 1, 93, 7, 16'hdb00, 9, 16'hdb00, 1, 0, 10, 7);
    scen(`HIRES_PERIOD_ENABLE_MODE_UP, 1, 1, 93, 5, 16'h8000, 9, 16'hdb00, 3, 1, 10, 5);
    scen(`HIRES_PERIOD_ENABLE_MODE_UPDOWN, 1, 1, 93, 5, 16'h4000, 9, 16'hdb00, 1, 1, 18, 9);
    scen(`HIRES_PERIOD_ENABLE_MODE_DOWN, 0, 0, 93, 5, 16'h7700, 9, 0, 2, 1, 10, 5);
    for (i = 0; i < 3; i = i + 1)
    begin
        rk = $random(seed);
        rf = $random(seed);
        scen(`HIRES_PERIOD_ENABLE_MODE_UP, 0, 1, rk, 5, rf, 9, 0, 1, 1, 10, 5);
    end
    scen(`HIRES_PERIOD_ENABLE_MODE_UP, 0, 0, 93, 0, 16'hff00, 9, 0, 0, 0, 0, 0);
    test_done;
end
// Report counts and the verdict, then stop
task test_done;
begin
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
end
endtask
endmodule // hires_period_enable_top_test
